/* File: hw/tsbl_pkg.sv */
// Purpose: shared constants and state types for tool start and button logic
// Assumes: CLK at 10 MHz, one millisecond time base derived from it
// Notes:   all button and enable times are counted in millisecond ticks
package tsbl_pkg;

	// -------------------------------------------------------------------
	// clock and time base
	// -------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    =
		(TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// -------------------------------------------------------------------
	// timing constants in milliseconds, two-hand window given in seconds
	// -------------------------------------------------------------------
	localparam real TWO_HAND_WINDOW_S = 0.5;
	localparam int  TWO_HAND_TICKS    = int'(TWO_HAND_WINDOW_S * 1000.0);
	localparam int  DEBOUNCE_MS       = 5;
	localparam int  FLASH_ON_MS       = 100;
	localparam int  FLASH_OFF_MS      = 100;

	// -------------------------------------------------------------------
	// widths and codes
	// -------------------------------------------------------------------
	localparam int         TIME_W     = 16;
	localparam int         TH_CNT_W   = 10;
	localparam int         LED_CNT_W  = 8;
	localparam int         FUNC_W     = 4;
	localparam int         NUM_FUNC   = 15;
	localparam logic [3:0] FUNC_NONE  = 4'h0;
	localparam logic [1:0] FLASH_ONE  = 2'h1;
	localparam logic [1:0] FLASH_TWO  = 2'h2;
	localparam logic [1:0] FLASH_RST  = 2'h0;

	// -------------------------------------------------------------------
	// state enumerations
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		TH_IDLE,
		TH_ARMED,
		TH_RUN,
		TH_RELEASE
	} tsbl_hand_t;

	typedef enum logic [2:0] {
		BT_IDLE,
		BT_FIRST,
		BT_GAP,
		BT_SECOND,
		BT_HELD
	} tsbl_btn_t;

endpackage : tsbl_pkg

/* File: hw/tsbl_tick.sv */
// Purpose: divider giving a one-cycle millisecond enable pulse
// Assumes: DIV of at least one clock
// Notes:   tick is registered
module tsbl_tick #(
	parameter int DIV = tsbl_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// time base
	output logic      tick
);
	localparam int CNT_W = $clog2(DIV + 1);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic          tick;
	} tsbl_tick_t;

	tsbl_tick_t s;
	tsbl_tick_t next_s;

	// count clocks, pulse at wrap
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == CNT_W'(DIV - 1)) begin
			next_s.cnt  = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule : tsbl_tick

/* File: hw/tsbl_debounce.sv */
// Purpose: two-stage synchroniser and tick-based debounce of one pin
// Assumes: tick is a one-cycle pulse on clk
// Notes:   clean changes after STABLE steady ticks
module tsbl_debounce #(
	parameter int STABLE = tsbl_pkg::DEBOUNCE_MS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// time base and pin
	input  wire logic tick,
	input  wire logic raw,
	// filtered level
	output logic      clean
);
	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       clean;
		logic [7:0] cnt;
	} tsbl_deb_t;

	tsbl_deb_t s;
	tsbl_deb_t next_s;

	// synchronise, then accept a level once it has stood
	always_comb begin
		next_s = s;
		next_s.sync1 = raw;
		next_s.sync2 = s.sync1;
		if (s.sync2 == s.clean) begin
			next_s.cnt = '0;
		end else if (tick) begin
			if (s.cnt == 8'(STABLE - 1)) begin
				next_s.clean = s.sync2;
				next_s.cnt   = '0;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign clean = s.clean;
endmodule : tsbl_debounce

/* File: hw/tsbl_top.sv */
// Purpose: start interlock, timed enable and function button classifier
// Assumes: config inputs come from logic on CLK; trigger pins are raw
// Notes:   all times are millisecond ticks from one divider
module tsbl_top #(
	parameter int TICK_DIV = tsbl_pkg::TICK_CYCLES,
	parameter int TIME_W   = tsbl_pkg::TIME_W,
	parameter int NUM_FUNC = tsbl_pkg::NUM_FUNC
) (
	// clock and reset
	input  wire logic                         CLK,
	input  wire logic                         RST_N,
	// raw tool pins
	input  wire logic                         START_TRIG,
	input  wire logic                         SAFETY_TRIG,
	input  wire logic                         FUNC_BUTTON,
	input  wire logic                         TIMER_ENABLE_IN,
	// start configuration
	input  wire logic                         START_SOURCE_SELECT,
	input  wire logic                         GPIO4_UNUSED,
	input  wire logic                         TIMED_ENABLE_ON,
	input  wire logic [TIME_W-1:0]            ENABLE_TIME_MS,
	// button configuration
	input  wire logic [TIME_W-1:0]            PRESS_LIMIT_MS,
	input  wire logic [TIME_W-1:0]            NEXT_PRESS_LIMIT_MS,
	input  wire logic                         COUNTER_CLOCKWISE_DIR,
	input  wire logic [tsbl_pkg::FUNC_W-1:0]  BUTTON_ACTION_MAP_FIRST,
	input  wire logic [tsbl_pkg::FUNC_W-1:0]  CW_DOUBLE_ACTION_MAP,
	input  wire logic [tsbl_pkg::FUNC_W-1:0]  CW_HELD_ACTION_MAP,
	input  wire logic [tsbl_pkg::FUNC_W-1:0]  CCW_SINGLE_ACTION_MAP,
	input  wire logic [tsbl_pkg::FUNC_W-1:0]  CCW_DOUBLE_ACTION_MAP,
	input  wire logic [tsbl_pkg::FUNC_W-1:0]  CCW_HELD_ACTION_MAP,
	// alert configuration
	input  wire logic                         ROTATION_ALERT_ON,
	input  wire logic                         ROTATION_ALERT_KIND,
	// motor and enable
	output logic                              MOTOR_RUN,
	output logic                              TOOL_ENABLED,
	// input functions and events
	output logic [NUM_FUNC-1:0]               FUNC_OUT,
	output logic                              SINGLE_PUSH,
	output logic                              DOUBLE_PUSH,
	output logic                              HELD_PRESS,
	// operator feedback
	output logic                              LED_FLASH,
	output logic                              ALERT_SOUND,
	output logic                              ALERT_INDICATOR
);
	localparam logic [tsbl_pkg::TH_CNT_W-1:0] TH_LAST =
		tsbl_pkg::TH_CNT_W'(tsbl_pkg::TWO_HAND_TICKS - 1);
	localparam logic [tsbl_pkg::LED_CNT_W-1:0] ON_LAST =
		tsbl_pkg::LED_CNT_W'(tsbl_pkg::FLASH_ON_MS - 1);
	localparam logic [tsbl_pkg::LED_CNT_W-1:0] OFF_LAST =
		tsbl_pkg::LED_CNT_W'(tsbl_pkg::FLASH_OFF_MS - 1);

	// local names for the package state codes
	localparam tsbl_pkg::tsbl_hand_t TH_IDLE    = tsbl_pkg::TH_IDLE;
	localparam tsbl_pkg::tsbl_hand_t TH_ARMED   = tsbl_pkg::TH_ARMED;
	localparam tsbl_pkg::tsbl_hand_t TH_RUN     = tsbl_pkg::TH_RUN;
	localparam tsbl_pkg::tsbl_hand_t TH_RELEASE = tsbl_pkg::TH_RELEASE;
	localparam tsbl_pkg::tsbl_btn_t  BT_IDLE    = tsbl_pkg::BT_IDLE;
	localparam tsbl_pkg::tsbl_btn_t  BT_FIRST   = tsbl_pkg::BT_FIRST;
	localparam tsbl_pkg::tsbl_btn_t  BT_GAP     = tsbl_pkg::BT_GAP;
	localparam tsbl_pkg::tsbl_btn_t  BT_SECOND  = tsbl_pkg::BT_SECOND;
	localparam tsbl_pkg::tsbl_btn_t  BT_HELD    = tsbl_pkg::BT_HELD;

	typedef struct packed {
		tsbl_pkg::tsbl_hand_t               th;
		logic [tsbl_pkg::TH_CNT_W-1:0]      th_cnt;
		logic                               run;
		logic                               en;
		logic [TIME_W-1:0]                  en_cnt;
		logic                               en_prev;
		tsbl_pkg::tsbl_btn_t                bst;
		logic [TIME_W-1:0]                  b_cnt;
		logic                               single_ev;
		logic                               double_ev;
		logic                               held;
		logic [NUM_FUNC-1:0]                func;
		logic [1:0]                         flashes;
		logic                               led;
		logic [tsbl_pkg::LED_CNT_W-1:0]     led_cnt;
		logic                               alert_snd;
		logic                               alert_ind;
	} tsbl_state_t;

	tsbl_state_t s;
	tsbl_state_t next_s;

	logic                        tick;
	logic                        start_c;
	logic                        safety_c;
	logic                        button_c;
	logic                        enable_c;
	logic                        two_hand;
	logic                        allow;
	logic                        en_rise;
	logic                        no_push_map;
	logic [tsbl_pkg::FUNC_W-1:0] map_s;
	logic [tsbl_pkg::FUNC_W-1:0] map_d;
	logic [tsbl_pkg::FUNC_W-1:0] map_h;

	// -------------------------------------------------------------------
	// time base and input conditioning
	// -------------------------------------------------------------------
	tsbl_tick #(.DIV(TICK_DIV)) u_tick (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick)
	);

	tsbl_debounce u_deb_start (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.raw   (START_TRIG),
		.clean (start_c)
	);

	tsbl_debounce u_deb_safety (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.raw   (SAFETY_TRIG),
		.clean (safety_c)
	);

	tsbl_debounce u_deb_button (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.raw   (FUNC_BUTTON),
		.clean (button_c)
	);

	tsbl_debounce u_deb_enable (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.raw   (TIMER_ENABLE_IN),
		.clean (enable_c)
	);

	// -------------------------------------------------------------------
	// mode and direction decode
	// -------------------------------------------------------------------
	// two-hand only with the safety input free
	assign two_hand = START_SOURCE_SELECT & GPIO4_UNUSED;
	assign allow    = !TIMED_ENABLE_ON | s.en;
	assign en_rise  = enable_c & !s.en_prev;
	// per-direction function maps
	assign map_s = COUNTER_CLOCKWISE_DIR ? CCW_SINGLE_ACTION_MAP
	                                     : BUTTON_ACTION_MAP_FIRST;
	assign map_d = COUNTER_CLOCKWISE_DIR ? CCW_DOUBLE_ACTION_MAP
	                                     : CW_DOUBLE_ACTION_MAP;
	assign map_h = COUNTER_CLOCKWISE_DIR ? CCW_HELD_ACTION_MAP
	                                     : CW_HELD_ACTION_MAP;
	assign no_push_map = (map_s == tsbl_pkg::FUNC_NONE) &&
	                     (map_d == tsbl_pkg::FUNC_NONE);

	// -------------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.single_ev = 1'b0;
		next_s.double_ev = 1'b0;
		next_s.en_prev   = enable_c;

		// two-hand interlock
		unique case (s.th)
			TH_IDLE: begin
				next_s.th_cnt = '0;
				if (two_hand && start_c && safety_c && allow) begin
					next_s.th = TH_RUN;
				end else if (two_hand && (start_c || safety_c)) begin
					next_s.th = TH_ARMED;
				end
			end
			TH_ARMED: begin
				if (!two_hand || (!start_c && !safety_c)) begin
					next_s.th = TH_IDLE;
				end else if (start_c && safety_c && allow) begin
					next_s.th = TH_RUN;
				end else if (tick) begin
					if (s.th_cnt == TH_LAST) begin
						next_s.th = TH_RELEASE;
					end else begin
						next_s.th_cnt = s.th_cnt + 1'b1;
					end
				end
			end
			TH_RUN: begin
				if (!two_hand || !start_c || !safety_c) begin
					next_s.th = TH_RELEASE;
				end
			end
			TH_RELEASE: begin
				if (!start_c && !safety_c) begin
					next_s.th = TH_IDLE;
				end
			end
		endcase

		// motor command
		if (two_hand) begin
			next_s.run = (next_s.th == TH_RUN);
		end else begin
			next_s.run = start_c && allow;
		end

		// timed enable window
		if (!TIMED_ENABLE_ON) begin
			next_s.en     = 1'b0;
			next_s.en_cnt = '0;
		end else if (en_rise || s.run) begin
			next_s.en     = 1'b1;
			next_s.en_cnt = ENABLE_TIME_MS;
		end else if (s.en && tick) begin
			if (s.en_cnt <= TIME_W'(1)) begin
				next_s.en     = 1'b0;
				next_s.en_cnt = '0;
			end else begin
				next_s.en_cnt = s.en_cnt - 1'b1;
			end
		end

		// function button classifier
		unique case (s.bst)
			BT_IDLE: begin
				next_s.b_cnt = '0;
				if (button_c) begin
					next_s.bst = no_push_map ? BT_HELD : BT_FIRST;
				end
			end
			BT_FIRST: begin
				if (!button_c) begin
					next_s.bst   = BT_GAP;
					next_s.b_cnt = '0;
				end else if (tick) begin
					if (s.b_cnt + 1'b1 >= PRESS_LIMIT_MS) begin
						next_s.bst = BT_HELD;
					end else begin
						next_s.b_cnt = s.b_cnt + 1'b1;
					end
				end
			end
			BT_GAP: begin
				if (button_c) begin
					next_s.bst   = BT_SECOND;
					next_s.b_cnt = '0;
				end else if (tick) begin
					if (s.b_cnt + 1'b1 >= NEXT_PRESS_LIMIT_MS) begin
						next_s.bst       = BT_IDLE;
						next_s.single_ev = 1'b1;
					end else begin
						next_s.b_cnt = s.b_cnt + 1'b1;
					end
				end
			end
			BT_SECOND: begin
				if (!button_c) begin
					next_s.bst       = BT_IDLE;
					next_s.double_ev = 1'b1;
				end else if (tick) begin
					if (s.b_cnt + 1'b1 >= PRESS_LIMIT_MS) begin
						next_s.bst = BT_HELD;
					end else begin
						next_s.b_cnt = s.b_cnt + 1'b1;
					end
				end
			end
			BT_HELD: begin
				if (!button_c) begin
					next_s.bst = BT_IDLE;
				end
			end
			default: begin
				next_s.bst = BT_IDLE;
			end
		endcase
		next_s.held = (next_s.bst == BT_HELD);

		// pulses for pushes, level for held
		for (int k = 0; k < NUM_FUNC; k++) begin
			next_s.func[k] =
				(next_s.single_ev && map_s == tsbl_pkg::FUNC_W'(k + 1)) ||
				(next_s.double_ev && map_d == tsbl_pkg::FUNC_W'(k + 1)) ||
				(next_s.held && map_h == tsbl_pkg::FUNC_W'(k + 1));
		end

		// LED flash feedback
		if (next_s.single_ev && map_s != tsbl_pkg::FUNC_NONE) begin
			next_s.flashes = tsbl_pkg::FLASH_ONE;
			next_s.led     = 1'b1;
			next_s.led_cnt = '0;
		end else if (next_s.double_ev && map_d != tsbl_pkg::FUNC_NONE) begin
			next_s.flashes = tsbl_pkg::FLASH_TWO;
			next_s.led     = 1'b1;
			next_s.led_cnt = '0;
		end else if (tick && s.flashes != tsbl_pkg::FLASH_RST) begin
			if (s.led && s.led_cnt == ON_LAST) begin
				next_s.led     = 1'b0;
				next_s.led_cnt = '0;
				next_s.flashes = s.flashes - 1'b1;
			end else if (!s.led && s.led_cnt == OFF_LAST) begin
				next_s.led     = 1'b1;
				next_s.led_cnt = '0;
			end else begin
				next_s.led_cnt = s.led_cnt + 1'b1;
			end
		end

		// direction alert while rotating counter-clockwise
		next_s.alert_snd = ROTATION_ALERT_ON && !ROTATION_ALERT_KIND &&
		                   COUNTER_CLOCKWISE_DIR;
		next_s.alert_ind = ROTATION_ALERT_ON && ROTATION_ALERT_KIND &&
		                   COUNTER_CLOCKWISE_DIR;
	end

	// state register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign MOTOR_RUN       = s.run;
	assign TOOL_ENABLED    = allow;
	assign FUNC_OUT        = s.func;
	assign SINGLE_PUSH     = s.single_ev;
	assign DOUBLE_PUSH     = s.double_ev;
	assign HELD_PRESS      = s.held;
	assign LED_FLASH       = s.led;
	assign ALERT_SOUND     = s.alert_snd;
	assign ALERT_INDICATOR = s.alert_ind;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_single_pulse;
		s.single_ev ##1 !s.single_ev;
	endsequence

	sequence s_one_flash_load;
		s.flashes == tsbl_pkg::FLASH_ONE && s.led;
	endsequence

	AST_TH_BOTH: assert property (two_hand && $past(two_hand) &&
		$rose(s.run) |-> $past(start_c) && $past(safety_c))
		else $error("two-hand start without both triggers");
	AST_TH_STOP: assert property (two_hand && s.run &&
		(!start_c || !safety_c) |=> !s.run)
		else $error("tool kept running after trigger release");
	AST_TH_REARM: assert property (s.th == TH_RELEASE &&
		(start_c || safety_c) |=> s.th == TH_RELEASE && !s.run)
		else $error("restart before both triggers released");
	AST_TH_GATE: assert property (!two_hand && !start_c |=> !s.run)
		else $error("run without start trigger outside two-hand");
	AST_EN_HOLD: assert property (TIMED_ENABLE_ON && !s.en && !en_rise
		&& !s.run |=> !s.run)
		else $error("tool started while disabled");
	AST_EN_RISE: assert property (TIMED_ENABLE_ON && en_rise |=>
		s.en && s.en_cnt == $past(ENABLE_TIME_MS))
		else $error("enable request not loading window");
	AST_EN_RUN: assert property (TIMED_ENABLE_ON && s.run |=> s.en)
		else $error("enable dropped during run");
	AST_BT_IMM: assert property (s.bst == BT_IDLE && button_c &&
		no_push_map |=> s.held ##1 (s.held || !button_c))
		else $error("held not asserted at once");
	AST_BT_REL: assert property (s.held && !button_c |=> !s.held)
		else $error("held kept after release");
	AST_BT_SINGLE: assert property (s.bst == BT_GAP && !button_c && tick
		&& s.b_cnt + 1'b1 >= NEXT_PRESS_LIMIT_MS |=> s_single_pulse)
		else $error("single push not reported as one pulse");
	AST_LED_ONE: assert property (next_s.single_ev &&
		map_s != tsbl_pkg::FUNC_NONE |=> s_one_flash_load)
		else $error("single push flash not started");
	AST_LED_NONE: assert property (next_s.double_ev &&
		map_d == tsbl_pkg::FUNC_NONE && !tick |=>
		s.flashes == $past(s.flashes))
		else $error("flash given for unmapped push");
endmodule : tsbl_top

/* File: test/tsbl_operator.sv */
// Purpose: operator hands and controller input driving the raw tool pins
// Assumes: want bits change just after a CLK rising edge
// Notes:   each change chatters for five cycles, well under the debounce
module tsbl_operator (
	// clock
	input  wire logic       clk,
	// wanted levels: start, safety, button, enable input
	input  wire logic [3:0] want,
	// raw pins seen by the tool
	output logic      [3:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] last = 4'h0;
	int         age [4] = '{default: 99};

	initial pin = 4'h0;

	// contact bounce: alternating levels for a few cycles after a change
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (want[i] !== last[i]) begin
				last[i] <= want[i];
				age[i]  <= 0;
			end else if (age[i] < 99) begin
				age[i] <= age[i] + 1;
			end
			pin[i] <= (age[i] inside {[1:5]}) ? last[i] ^ age[i][0] : last[i];
		end
	end
endmodule : tsbl_operator

/* File: test/tool_start_and_button_logic_bench.sv */
// Purpose: self-checking bench for tool start and button logic
// Assumes: TICK_DIV of 10, so one ms is ten CLK cycles
// Notes:   button cases in a table, start and enable cases by hand
module tool_start_and_button_logic_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// stimulus and observation
	// ---------------------------------------------------------------
	typedef struct {
		logic        dir;
		int          p1, gap, p2, ev;
		logic [14:0] mask;
		int          fl;
	} tsbl_row_t;

	logic        CLK = 1'b0;
	logic        RST_N = 1'b0;
	logic [3:0]  want = 4'h0;
	wire  [3:0]  pins;
	logic        sel = 1'b0, g4 = 1'b0, ten = 1'b0, dir = 1'b0;
	logic        al_on = 1'b0, al_kind = 1'b0;
	logic [15:0] en_ms = 16'h001E, lim = 16'h0014;
	logic [3:0]  cw_s = 4'h1, cw_d = 4'h2, cw_h = 4'h3;
	logic [3:0]  ccw_s = 4'h4, ccw_d = 4'h0, ccw_h = 4'h6;
	logic        MOTOR_RUN, TOOL_ENABLED, SINGLE_PUSH, DOUBLE_PUSH;
	logic        HELD_PRESS, LED_FLASH, ALERT_SOUND, ALERT_INDICATOR;
	logic [14:0] FUNC_OUT, fobs;
	logic        led_d, last_held, h_rel;
	int          mismatches = 0, checked = 0, t;
	int          n_s, n_d, n_h, n_f, n_led;
	tsbl_row_t   rows [6] = '{
		'{1'b0, 8, 0, 0, 1, 15'h0001, 1}, '{1'b0, 8, 8, 8, 2, 15'h0002, 2},
		'{1'b0, 40, 0, 0, 3, 15'h0004, 0}, '{1'b1, 8, 0, 0, 1, 15'h0008, 1},
		'{1'b1, 8, 8, 8, 2, 15'h0000, 0}, '{1'b1, 40, 0, 0, 3, 15'h0020, 0}};

	always #50 CLK = ~CLK;

	tsbl_operator i_op (.clk(CLK), .want(want), .pin(pins));

	tsbl_top #(.TICK_DIV(10)) i_dut (
		.CLK(CLK), .RST_N(RST_N), .START_TRIG(pins[0]),
		.SAFETY_TRIG(pins[1]), .FUNC_BUTTON(pins[2]),
		.TIMER_ENABLE_IN(pins[3]), .START_SOURCE_SELECT(sel),
		.GPIO4_UNUSED(g4), .TIMED_ENABLE_ON(ten), .ENABLE_TIME_MS(en_ms),
		.PRESS_LIMIT_MS(lim), .NEXT_PRESS_LIMIT_MS(lim),
		.COUNTER_CLOCKWISE_DIR(dir), .BUTTON_ACTION_MAP_FIRST(cw_s),
		.CW_DOUBLE_ACTION_MAP(cw_d), .CW_HELD_ACTION_MAP(cw_h),
		.CCW_SINGLE_ACTION_MAP(ccw_s), .CCW_DOUBLE_ACTION_MAP(ccw_d),
		.CCW_HELD_ACTION_MAP(ccw_h), .ROTATION_ALERT_ON(al_on),
		.ROTATION_ALERT_KIND(al_kind), .MOTOR_RUN(MOTOR_RUN),
		.TOOL_ENABLED(TOOL_ENABLED), .FUNC_OUT(FUNC_OUT),
		.SINGLE_PUSH(SINGLE_PUSH), .DOUBLE_PUSH(DOUBLE_PUSH),
		.HELD_PRESS(HELD_PRESS), .LED_FLASH(LED_FLASH),
		.ALERT_SOUND(ALERT_SOUND), .ALERT_INDICATOR(ALERT_INDICATOR));

	// event counters, sampled away from the active edge
	always @(negedge CLK) begin
		n_s = n_s + (SINGLE_PUSH === 1'b1);
		n_d = n_d + (DOUBLE_PUSH === 1'b1);
		n_h = n_h + (HELD_PRESS === 1'b1);
		n_f = n_f + (FUNC_OUT !== 15'h0000);
		n_led = n_led + (LED_FLASH === 1'b1 && led_d !== 1'b1);
		fobs = fobs | FUNC_OUT;
		led_d = LED_FLASH;
		last_held = HELD_PRESS;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input int exp, input logic [15:0] got);
		checked++;
		if (got !== 16'(exp)) begin
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
			mismatches++;
		end
	endtask : chk

	task tally_and_finish;
		if (mismatches == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic ms(input int n);
		repeat (n * 10) @(posedge CLK);
	endtask : ms

	function automatic logic pick(input int k);
		return (k == 0) ? MOTOR_RUN : TOOL_ENABLED;
	endfunction : pick

	// bounded wait for a level, cycles taken in took
	task automatic wait_lvl(input string nm, input int k, input logic v,
			input int lim_ms, output int took);
		took = 0;
		while (pick(k) !== v) begin
			@(negedge CLK);
			took++;
			if (took > lim_ms * 10) begin
				chk(nm, v, 16'(pick(k)));
				tally_and_finish;
			end
		end
		@(posedge CLK);
	endtask : wait_lvl

	// level must hold for the whole span
	task automatic stay(input string nm, input int k, input logic v,
			input int n);
		int bad;
		bad = 0;
		repeat (n * 10) begin
			@(negedge CLK);
			bad = bad + (pick(k) !== v);
		end
		chk(nm, 0, 16'(bad));
		@(posedge CLK);
	endtask : stay

	task automatic clr;
		n_s = 0; n_d = 0; n_h = 0; n_f = 0; n_led = 0; fobs = 15'h0000;
	endtask : clr

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		clr();
		repeat (12) @(posedge CLK);
		chk("rst_motor", 0, 16'(MOTOR_RUN));
		chk("rst_enabled", 1, 16'(TOOL_ENABLED));
		RST_N <= 1'b1;
		ms(2);
		// button table: single, double, held in both directions
		foreach (rows[i]) begin
			dir <= rows[i].dir;
			ms(5);
			clr();
			want[2] <= 1'b1;
			ms(rows[i].p1);
			h_rel = last_held;
			want[2] <= 1'b0;
			if (rows[i].gap > 0) begin
				ms(rows[i].gap);
				want[2] <= 1'b1;
				ms(rows[i].p2);
				want[2] <= 1'b0;
			end
			ms(400);
			chk("single", rows[i].ev == 1, 16'(n_s));
			chk("double", rows[i].ev == 2, 16'(n_d));
			chk("held", rows[i].ev == 3, 16'(n_h > 0));
			chk("func", int'(rows[i].mask), 16'(fobs));
			chk("flash", rows[i].fl, 16'(n_led));
			if (rows[i].ev == 3) chk("held_down", 1, 16'(h_rel));
			else if (rows[i].mask != 0) chk("pulse", 1, 16'(n_f));
		end
		// no single or double map: held without press limit
		cw_s <= 4'h0;
		cw_d <= 4'h0;
		dir <= 1'b0;
		ms(5);
		want[2] <= 1'b1;
		ms(12);
		chk("held_at_once", 1, 16'(last_held));
		want[2] <= 1'b0;
		cw_s <= 4'h1;
		cw_d <= 4'h2;
		ms(50);
		// direction alert kinds
		al_on <= 1'b1;
		for (int j = 0; j < 3; j++) begin
			dir <= (j < 2);
			al_kind <= (j == 1);
			ms(1);
			chk("alert", (j == 0) ? 2 : int'(j == 1),
				16'({ALERT_SOUND, ALERT_INDICATOR}));
		end
		// two-hand start
		sel <= 1'b1;
		g4 <= 1'b1;
		want[0] <= 1'b1;
		stay("one_hand", 0, 1'b0, 100);
		want[1] <= 1'b1;
		wait_lvl("two_hand", 0, 1'b1, 12, t);
		want[1] <= 1'b0;
		wait_lvl("hand_off", 0, 1'b0, 10, t);
		want[1] <= 1'b1;
		stay("no_restart", 0, 1'b0, 30);
		want[1:0] <= 2'h0;
		ms(20);
		want[1] <= 1'b1;
		ms(450);
		want[0] <= 1'b1;
		wait_lvl("safety_first", 0, 1'b1, 12, t);
		want[1:0] <= 2'h0;
		ms(20);
		want[0] <= 1'b1;
		ms(600);
		want[1] <= 1'b1;
		stay("too_late", 0, 1'b0, 30);
		want[1:0] <= 2'h0;
		ms(20);
		// input 4 in use: plain start
		g4 <= 1'b0;
		want[0] <= 1'b1;
		wait_lvl("gpio4_used", 0, 1'b1, 12, t);
		RST_N <= 1'b0;
		@(negedge CLK);
		chk("mid_rst", 0, 16'(MOTOR_RUN));
		@(posedge CLK);
		want[0] <= 1'b0;
		ms(2);
		RST_N <= 1'b1;
		ms(20);
		// timed enable
		sel <= 1'b0;
		ten <= 1'b1;
		ms(1);
		chk("disabled", 0, 16'(TOOL_ENABLED));
		want[0] <= 1'b1;
		stay("no_run", 0, 1'b0, 20);
		want[0] <= 1'b0;
		want[3] <= 1'b1;
		wait_lvl("en_rise", 1, 1'b1, 12, t);
		wait_lvl("en_end", 1, 1'b0, 40, t);
		chk("en_len", 1, 16'(t >= 280 && t <= 310));
		stay("steady_high", 1, 1'b0, 50);
		want[3] <= 1'b0;
		ms(10);
		want[3] <= 1'b1;
		wait_lvl("en_again", 1, 1'b1, 12, t);
		want[0] <= 1'b1;
		wait_lvl("en_run", 0, 1'b1, 12, t);
		stay("en_kept", 1, 1'b1, 60);
		want[0] <= 1'b0;
		wait_lvl("en_stop", 0, 1'b0, 12, t);
		wait_lvl("en_after", 1, 1'b0, 40, t);
		chk("en_after_len", 1, 16'(t >= 280 && t <= 320));
		tally_and_finish;
	end
endmodule : tool_start_and_button_logic_bench
